// *** design/mmcg_guard.sv ***
// Mode-based guard for the MMU segmentation configuration registers
// Behaviour
// - Boot and test mode code may reach all memory and every register group, but cannot write the segment table pointer.
// - Contactless mode code is confined to its own fixed memory partition, system and user code kept out of it.
// - System mode code may rewrite the segment table pointer and change table entries in writable memory.
// - User mode code gets no access at all to the segmentation configuration registers.
// - Segment table entries get only ordinary memory permissions, so any mode with write rights may change them.
// - Reset clears the segment table pointer to zero, which disables every segment and blocks user code.
// - The memory partition is fixed in every mode and no register or write can move it.
// - Nothing can replace the reset defaults of the attribute registers with other initial values.
// - The segmentation configuration registers can be modified only from system mode.
// - The set of attribute registers is fixed and none can be created at run time.
// - User mode access to hardware component registers follows the right of the executing segment.
`timescale 1ns/1ps
`default_nettype none
module mmcg_guard
(
	input  wire logic                          clock,      // 200 MHz clock
	input  wire logic                          nrst,       // Synchronous reset, active low
	input  wire logic                          ce,         // Clock enable, freezes all state when low
	input  wire logic [2:0]                    cpuMode,    // Current CPU mode code
	input  wire logic                          sfrValid,   // Register access request
	input  wire logic                          sfrWrite,   // Register access is a write
	input  wire logic [mmcg_pkg::SFR_AW-1:0]   sfrAddr,    // Register address
	input  wire logic [mmcg_pkg::DW-1:0]       sfrWdata,   // Register write data
	input  wire logic                          segSfrOk,   // Executing segment grants hardware registers
	input  wire logic                          memValid,   // Memory access request
	input  wire logic                          memWrite,   // Memory access is a write
	input  wire logic [mmcg_pkg::MEM_AW-1:0]   memAddr,    // Memory address
	input  wire logic                          segRead,    // Addressed segment grants read
	input  wire logic                          segWrite,   // Addressed segment grants write
	output logic                               sfrGrant,   // Register access allowed, pulse
	output logic                               sfrDeny,    // Register access refused, pulse
	output logic [mmcg_pkg::DW-1:0]            sfrRdata,   // Read data of a granted pointer read
	output logic                               memGrant,   // Memory access allowed, pulse
	output logic                               memDeny,    // Memory access refused, pulse
	output logic [2*mmcg_pkg::DW-1:0]          tableBase,  // Segment table pointer to the MMU
	output logic                               segEnabled  // Pointer non-zero, segments live
);
	mmcg_pkg::mmcg_mode_t mode;
	logic [mmcg_pkg::DW-1:0] tblLo_ff, tblHi_ff;
	logic sfrGrant_ff, sfrDeny_ff, memGrant_ff, memDeny_ff, segEnabled_ff;
	logic [mmcg_pkg::DW-1:0] sfrRdata_ff, nxt_sfrRdata;
	logic isCfg, isGen, isSys, isHw, sfrOk, cfgWrite, tblEnabled;
	logic [2*mmcg_pkg::DW-1:0] nxt_tableBase;

	mmcg_seg_if segBus ();

	assign mode = mmcg_pkg::mmcg_mode_t'(cpuMode);
	assign tblEnabled = ({tblHi_ff, tblLo_ff} != {mmcg_pkg::TBL_BASE_RESET, mmcg_pkg::TBL_BASE_RESET});

	// Register group decode; only the two pointer bytes are stored here
	assign isCfg = (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_LO) || (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_HI);
	assign isGen = (sfrAddr >= mmcg_pkg::GEN_LO) && (sfrAddr <= mmcg_pkg::GEN_HI);
	assign isSys = (sfrAddr >= mmcg_pkg::SYS_LO) && (sfrAddr <= mmcg_pkg::SYS_HI);
	assign isHw  = (sfrAddr >= mmcg_pkg::HW_LO) && (sfrAddr <= mmcg_pkg::HW_HI);

	// Access matrix; boot and test may read the pointer but only system mode writes it
	always_comb
	begin
		sfrOk = 1'b0;
		unique case (mode)
			mmcg_pkg::MODE_BOOT,
			mmcg_pkg::MODE_TEST:   sfrOk = !(isCfg && sfrWrite);
			mmcg_pkg::MODE_CLESS:  sfrOk = isGen || isHw;
			mmcg_pkg::MODE_SYSTEM: sfrOk = isCfg || isGen || isSys || isHw;
			mmcg_pkg::MODE_USER:   sfrOk = isGen || (isHw && segSfrOk && tblEnabled);
			default:               sfrOk = 1'b0; // Illegal mode code gets nothing
		endcase
	end

	assign cfgWrite = sfrValid && sfrWrite && isCfg && (mode == mmcg_pkg::MODE_SYSTEM);

	// Pointer write; a refused write never reaches the flops
	always_comb
	begin
		nxt_tableBase = {tblHi_ff, tblLo_ff};
		if (cfgWrite && (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_LO))
			nxt_tableBase[mmcg_pkg::DW-1:0] = sfrWdata;
		if (cfgWrite && (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_HI))
			nxt_tableBase[2*mmcg_pkg::DW-1:mmcg_pkg::DW] = sfrWdata;
	end

	// Pointer storage; reset value is a constant with no load path
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			tblLo_ff <= mmcg_pkg::TBL_BASE_RESET;
			tblHi_ff <= mmcg_pkg::TBL_BASE_RESET;
		end
		else if (ce)
		begin
			tblLo_ff <= nxt_tableBase[mmcg_pkg::DW-1:0];
			tblHi_ff <= nxt_tableBase[2*mmcg_pkg::DW-1:mmcg_pkg::DW];
		end
	end

	// Read data only for granted pointer reads, zero otherwise
	always_comb
	begin
		nxt_sfrRdata = mmcg_pkg::RDATA_NONE;
		if (sfrValid && !sfrWrite && sfrOk && (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_LO))
			nxt_sfrRdata = tblLo_ff;
		if (sfrValid && !sfrWrite && sfrOk && (sfrAddr == mmcg_pkg::ADDR_TBL_BASE_HI))
			nxt_sfrRdata = tblHi_ff;
	end

	// Register verdict, one cycle after the request
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			sfrGrant_ff <= 1'b0;
			sfrDeny_ff  <= 1'b0;
			sfrRdata_ff <= mmcg_pkg::RDATA_NONE;
		end
		else if (ce)
		begin
			sfrGrant_ff <= sfrValid && sfrOk;
			sfrDeny_ff  <= sfrValid && !sfrOk;
			sfrRdata_ff <= nxt_sfrRdata;
		end
	end

	// Memory requests go to the partition checker
	assign segBus.mode       = mode;
	assign segBus.memWrite   = memWrite;
	assign segBus.memAddr    = memAddr;
	assign segBus.segRead    = segRead;
	assign segBus.segWrite   = segWrite;
	assign segBus.tblEnabled = tblEnabled;

	mmcg_seg_check u_check
	(
		.seg (segBus.judge)
	);

	// Memory verdict, one cycle after the request
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			memGrant_ff   <= 1'b0;
			memDeny_ff    <= 1'b0;
			segEnabled_ff <= 1'b0;
		end
		else if (ce)
		begin
			memGrant_ff   <= memValid && segBus.memOk;
			memDeny_ff    <= memValid && !segBus.memOk;
			segEnabled_ff <= (nxt_tableBase != {mmcg_pkg::TBL_BASE_RESET, mmcg_pkg::TBL_BASE_RESET});
		end
	end

	assign sfrGrant   = sfrGrant_ff;
	assign sfrDeny    = sfrDeny_ff;
	assign sfrRdata   = sfrRdata_ff;
	assign memGrant   = memGrant_ff;
	assign memDeny    = memDeny_ff;
	assign tableBase  = {tblHi_ff, tblLo_ff};
	assign segEnabled = segEnabled_ff;

	// Checks; all share the clock, and all but reset_zero_a share the reset disable
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	ptr_write_lo_a: assert property (ce && sfrValid && sfrWrite && mode == mmcg_pkg::MODE_SYSTEM
		&& sfrAddr == mmcg_pkg::ADDR_TBL_BASE_LO |=> tableBase[mmcg_pkg::DW-1:0] == $past(sfrWdata))
		else $error("system write to pointer low byte lost");

	ptr_guard_a: assert property (!(ce && sfrValid && sfrWrite && isCfg && mode == mmcg_pkg::MODE_SYSTEM)
		|=> $stable(tableBase))
		else $error("pointer changed without a system mode write");

	user_cfg_deny_a: assert property (ce && sfrValid && isCfg && mode == mmcg_pkg::MODE_USER
		|=> sfrDeny && !sfrGrant && sfrRdata == mmcg_pkg::RDATA_NONE)
		else $error("user mode reached the configuration registers");

	boot_full_a: assert property (ce && sfrValid && !(isCfg && sfrWrite)
		&& (mode == mmcg_pkg::MODE_BOOT || mode == mmcg_pkg::MODE_TEST) |=> sfrGrant)
		else $error("boot or test access refused");

	reset_zero_a: assert property (disable iff (1'b0) !nrst |=> tableBase == '0 && !segEnabled)
		else $error("pointer not cleared by reset");

	user_blocked_a: assert property (ce && memValid && !tblEnabled && mode == mmcg_pkg::MODE_USER
		|=> memDeny && !memGrant)
		else $error("user memory access with segments disabled");

	cless_part_a: assert property (ce && memValid && mode == mmcg_pkg::MODE_CLESS
		|=> memGrant == ($past(memAddr) >= mmcg_pkg::CLESS_BASE))
		else $error("contactless access crossed the partition");

	user_hw_a: assert property (ce && sfrValid && isHw && mode == mmcg_pkg::MODE_USER && tblEnabled
		|=> sfrGrant == $past(segSfrOk))
		else $error("user hardware access ignores segment right");

	table_mem_a: assert property (ce && memValid && memWrite && mode == mmcg_pkg::MODE_USER && tblEnabled
		&& segWrite && memAddr < mmcg_pkg::CLESS_BASE |=> memGrant)
		else $error("writable segment refused to user mode");

	freeze_a: assert property (!ce |=> $stable(tableBase) && $stable(sfrGrant) && $stable(memGrant))
		else $error("state moved while clock enable low");

	cfg_refuse_a: assert property (ce && sfrValid && sfrWrite && isCfg && mode != mmcg_pkg::MODE_SYSTEM
		|=> sfrDeny && !sfrGrant)
		else $error("configuration write outside system mode accepted");

	sys_cfg_a: assert property (ce && sfrValid && isCfg && mode == mmcg_pkg::MODE_SYSTEM
		|=> sfrGrant && !sfrDeny)
		else $error("system mode refused the configuration registers");

	seg_flag_a: assert property (segEnabled == (tableBase != '0))
		else $error("segment enable flag disagrees with the pointer");

	sys_ptr_cv: cover property (cfgWrite && ce ##1 segEnabled);
	user_deny_cv: cover property (ce && sfrValid && isCfg && sfrWrite && mode == mmcg_pkg::MODE_USER);
	cless_ok_cv: cover property (ce && memValid && mode == mmcg_pkg::MODE_CLESS ##1 memGrant);
	user_mem_cv: cover property (ce && memValid && mode == mmcg_pkg::MODE_USER ##1 memGrant);
	freeze_cv: cover property (!ce && sfrValid);
endmodule
`default_nettype wire

// *** include/mmcg_pkg.sv ***
// Constants and types shared by the MMU configuration guard
package mmcg_pkg;
	// CPU modes as presented by the core; other codes are illegal
	typedef enum logic [2:0] {
		MODE_BOOT   = 3'h0,
		MODE_TEST   = 3'h1,
		MODE_CLESS  = 3'h2,
		MODE_SYSTEM = 3'h3,
		MODE_USER   = 3'h4
	} mmcg_mode_t;

	localparam int SFR_AW = 8;
	localparam int MEM_AW = 16;
	localparam int DW     = 8;

	// Segment table base pointer registers (segmentation configuration group)
	localparam logic [SFR_AW-1:0] ADDR_TBL_BASE_LO = 8'h91;
	localparam logic [SFR_AW-1:0] ADDR_TBL_BASE_HI = 8'h92;
	localparam logic [DW-1:0]     TBL_BASE_RESET   = 8'h00;

	// Register group windows, inclusive bounds
	localparam logic [SFR_AW-1:0] GEN_LO  = 8'h80;
	localparam logic [SFR_AW-1:0] GEN_HI  = 8'h8f;
	localparam logic [SFR_AW-1:0] SYS_LO  = 8'ha0;
	localparam logic [SFR_AW-1:0] SYS_HI  = 8'hbf;
	localparam logic [SFR_AW-1:0] HW_LO   = 8'hc0;
	localparam logic [SFR_AW-1:0] HW_HI   = 8'hff;

	// Fixed memory partition: contactless code owns everything from this address up
	localparam logic [MEM_AW-1:0] CLESS_BASE = 16'he000;

	localparam logic [DW-1:0] RDATA_NONE = 8'h00;
endpackage

// *** include/mmcg_seg_if.sv ***
// Memory access request and verdict between guard and partition checker
`timescale 1ns/1ps
`default_nettype none
interface mmcg_seg_if;
	mmcg_pkg::mmcg_mode_t    mode;       // Current CPU mode
	logic                    memWrite;   // Access is a write
	logic [mmcg_pkg::MEM_AW-1:0] memAddr; // Access address
	logic                    segRead;    // Segment grants read
	logic                    segWrite;   // Segment grants write
	logic                    tblEnabled; // Segment table pointer non-zero
	logic                    memOk;      // Verdict: access allowed

	modport guard (output mode, memWrite, memAddr, segRead, segWrite, tblEnabled, input memOk);
	modport judge (input mode, memWrite, memAddr, segRead, segWrite, tblEnabled, output memOk);
endinterface
`default_nettype wire

// *** design/mmcg_seg_check.sv ***
// Memory partition and segment permission check
`timescale 1ns/1ps
`default_nettype none
module mmcg_seg_check
(
	mmcg_seg_if.judge seg // Request in, verdict out
);
	logic inCless;

	// Partition boundary is a constant, nothing can move it
	assign inCless = (seg.memAddr >= mmcg_pkg::CLESS_BASE);

	// Verdict per mode; segment table memory gets ordinary permissions only
	always_comb
	begin
		seg.memOk = 1'b0;
		unique case (seg.mode)
			mmcg_pkg::MODE_BOOT,
			mmcg_pkg::MODE_TEST:   seg.memOk = 1'b1;
			mmcg_pkg::MODE_CLESS:  seg.memOk = inCless;
			mmcg_pkg::MODE_SYSTEM: seg.memOk = !inCless;
			mmcg_pkg::MODE_USER:   seg.memOk = !inCless && seg.tblEnabled
				&& (seg.memWrite ? seg.segWrite : seg.segRead);
			default:               seg.memOk = 1'b0; // Illegal mode code
		endcase
	end
endmodule
`default_nettype wire

// *** dv/mmcg_cpu_model.sv ***
// CPU core model issuing mode-tagged register and memory accesses
`timescale 1ns/1ps
`default_nettype none
module mmcg_cpu_model
(
	input  wire logic        clock,    // Core clock
	output logic [2:0]       cpuMode,  // Mode code
	output logic             sfrValid, // Register request
	output logic             sfrWrite, // Register write
	output logic [7:0]       sfrAddr,  // Register address
	output logic [7:0]       sfrWdata, // Register write data
	output logic             segSfrOk, // Segment grants hardware registers
	output logic             memValid, // Memory request
	output logic             memWrite, // Memory write
	output logic [15:0]      memAddr,  // Memory address
	output logic             segRead,  // Segment read right
	output logic             segWrite  // Segment write right
);
	// Idle at time zero
	initial
	begin
		{cpuMode, sfrValid, sfrWrite, sfrAddr, sfrWdata, segSfrOk} = '0;
		{memValid, memWrite, memAddr, segRead, segWrite} = '0;
	end

	// Register access held over the taking edge; on release address and write data flip so stale values cannot pass
	// Returns at the falling edge after the taking edge, while the one-cycle verdict still stands
	task automatic sfr(input logic [2:0] m, input logic w, input logic [7:0] a, input logic [7:0] d, input logic ok);
	begin
		@(negedge clock);
		{cpuMode, sfrWrite, sfrAddr, sfrWdata, segSfrOk, sfrValid} = {m, w, a, d, ok, 1'b1};
		@(negedge clock);
		sfrValid = 1'b0;
		{sfrAddr, sfrWdata} = ~{sfrAddr, sfrWdata};
	end
	endtask

	// Memory access, same handshake as the register path
	task automatic mem(input logic [2:0] m, input logic w, input logic [15:0] a, input logic rd, input logic wr);
	begin
		@(negedge clock);
		{cpuMode, memWrite, memAddr, segRead, segWrite, memValid} = {m, w, a, rd, wr, 1'b1};
		@(negedge clock);
		memValid = 1'b0;
		memAddr = ~memAddr;
	end
	endtask
endmodule
`default_nettype wire

// *** dv/mode_based_mmu_config_guard_bench.sv ***
// Self-checking bench for the MMU configuration guard
`timescale 1ns/1ps
`default_nettype none
module mode_based_mmu_config_guard_bench;
	logic        clock;
	logic        nrst;
	logic        ce = 1'b1;
	logic [2:0]  cpuMode;
	logic        sfrValid, sfrWrite, segSfrOk, memValid, memWrite, segRead, segWrite;
	logic [7:0]  sfrAddr, sfrWdata, sfrRdata;
	logic [15:0] memAddr, tableBase;
	logic        sfrGrant, sfrDeny, memGrant, memDeny, segEnabled;
	int          err_count = 0;
	int          cmp_count = 0;
	localparam logic [7:0] LO = mmcg_pkg::ADDR_TBL_BASE_LO;
	localparam logic [7:0] HI = mmcg_pkg::ADDR_TBL_BASE_HI;

	// Clock enable driven by the bench so that a frozen cycle is exercised too
	mmcg_guard i_dut (.clock, .nrst, .ce, .cpuMode, .sfrValid, .sfrWrite, .sfrAddr, .sfrWdata,
		.segSfrOk, .memValid, .memWrite, .memAddr, .segRead, .segWrite, .sfrGrant, .sfrDeny,
		.sfrRdata, .memGrant, .memDeny, .tableBase, .segEnabled);
	mmcg_cpu_model i_cpu (.clock, .cpuMode, .sfrValid, .sfrWrite, .sfrAddr, .sfrWdata, .segSfrOk,
		.memValid, .memWrite, .memAddr, .segRead, .segWrite);

	// Clock
	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	// Comparison of any result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	end
	endtask

	task automatic report_and_stop();
	begin
		$display("errors %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask

	// Reset leaves segments disabled, so user code gets no memory and no hardware registers
	task automatic t_reset_state();
	begin
		chk(tableBase, 16'h0000, "pointer");
		chk(16'(segEnabled), 16'h0000, "enabled");
		i_cpu.mem(3'h4, 1'b0, 16'h1000, 1'b1, 1'b1);
		chk({memGrant, memDeny}, 16'h0001, "user mem");
		i_cpu.sfr(3'h4, 1'b0, 8'hc0, 8'h00, 1'b1);
		chk({sfrGrant, sfrDeny}, 16'h0001, "user hw");
	end
	endtask

	// Pointer write from every mode, then reads; only system may modify
	task automatic t_ptr_modes();
	begin
		for (int m = 0; m < 6; m++)
		begin
			i_cpu.sfr(3'(m), 1'b1, LO, 8'h5a, 1'b0);
			chk({sfrGrant, sfrDeny}, (m == 3) ? 16'h2 : 16'h1, "ptr write");
			chk(tableBase, (m >= 3) ? 16'h005a : 16'h0000, "ptr kept");
		end
		for (int m = 0; m < 6; m++)
		begin
			i_cpu.sfr(3'(m), 1'b0, LO, 8'h00, 1'b0);
			chk({sfrGrant, sfrDeny, sfrRdata}, (m < 2 || m == 3) ? 16'h25a : 16'h100, "ptr read");
		end
	end
	endtask

	// System programs both bytes; a boot write elsewhere leaves the pointer alone
	task automatic t_sys_pointer();
	begin
		i_cpu.sfr(3'h3, 1'b1, HI, 8'h34, 1'b0);
		i_cpu.sfr(3'h3, 1'b1, LO, 8'h12, 1'b0);
		chk(tableBase, 16'h3412, "pointer");
		chk(16'(segEnabled), 16'h0001, "enabled");
		i_cpu.sfr(3'h3, 1'b0, HI, 8'h00, 1'b0);
		chk({sfrGrant, sfrRdata}, 16'h134, "hi read");
		i_cpu.sfr(3'h0, 1'b1, 8'h93, 8'hff, 1'b0);
		chk(tableBase, 16'h3412, "other write");
	end
	endtask

	// Fixed partition at the contactless boundary and ordinary segment rights
	task automatic t_partition();
		logic [2:0]  md [8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h0, 3'h4, 3'h4, 3'h4};
		logic [15:0] ad [8] = '{16'hdfff, 16'he000, 16'hdfff, 16'he000, 16'he000, 16'h1000, 16'h1000, 16'he000};
		logic [7:0]  sw = 8'b1010_0000;
		logic [7:0]  ex = 8'b0011_0110;
	begin
		for (int i = 0; i < 8; i++)
		begin
			i_cpu.mem(md[i], 1'b1, ad[i], 1'b1, sw[i]);
			chk({memGrant, memDeny}, {14'h0, ex[i], ~ex[i]}, "mem verdict");
		end
	end
	endtask

	// User hardware access follows the executing segment; pointer stays closed to user
	task automatic t_user_hw();
	begin
		i_cpu.sfr(3'h4, 1'b0, 8'hc0, 8'h00, 1'b1);
		chk({sfrGrant, sfrDeny}, 16'h2, "hw ok");
		i_cpu.sfr(3'h4, 1'b0, 8'hc0, 8'h00, 1'b0);
		chk({sfrGrant, sfrDeny}, 16'h1, "hw refused");
		i_cpu.sfr(3'h4, 1'b1, HI, 8'h00, 1'b1);
		chk(tableBase, 16'h3412, "user ptr");
		i_cpu.sfr(3'h1, 1'b0, 8'ha0, 8'h00, 1'b0);
		chk({sfrGrant, sfrDeny}, 16'h2, "test sys");
	end
	endtask

	// Clock enable low: a system write in that cycle is never taken and no verdict appears
	task automatic t_freeze();
	begin
		@(negedge clock);
		ce = 1'b0;
		i_cpu.sfr(3'h3, 1'b1, LO, 8'h77, 1'b0);
		chk({sfrGrant, sfrDeny}, 16'h0000, "frozen verdict");
		chk(tableBase, 16'h3412, "frozen pointer");
		ce = 1'b1;
		i_cpu.sfr(3'h3, 1'b1, LO, 8'h77, 1'b0);
		chk(tableBase, 16'h3477, "thawed pointer");
	end
	endtask

	// Reset in mid-run clears a live pointer and shuts user code out again
	task automatic t_reset_again();
	begin
		@(negedge clock);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		chk(tableBase, 16'h0000, "pointer after reset");
		chk(16'(segEnabled), 16'h0000, "enabled after reset");
		i_cpu.mem(3'h4, 1'b0, 16'h1000, 1'b1, 1'b1);
		chk({memGrant, memDeny}, 16'h0001, "user mem after reset");
	end
	endtask

	// Main sequence
	initial
	begin
		nrst = 1'b0;
		repeat (4) @(negedge clock);
		nrst = 1'b1;
		t_reset_state();
		t_ptr_modes();
		t_sys_pointer();
		t_partition();
		t_user_hw();
		t_freeze();
		t_reset_again();
		report_and_stop();
	end

	// Watchdog: the tests need well under a thousand cycles
	initial
	begin
		#20000;
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
